// ---- inc/i2cste_defines.svh ----
// register map, field positions and counts of the slave transmit engine
`ifndef I2CSTE_DEFINES_SVH
`define I2CSTE_DEFINES_SVH

`define I2CSTE_AW           3
`define I2CSTE_OFF_CTRL     3'h0
`define I2CSTE_OFF_STAT     3'h1
`define I2CSTE_OFF_DATA     3'h2
`define I2CSTE_OFF_OWN      3'h3
`define I2CSTE_OFF_MODE     3'h4
`define I2CSTE_OFF_SEC      3'h5

`define I2CSTE_CTRL_ENA     7
`define I2CSTE_CTRL_IEN     6
`define I2CSTE_CTRL_MST     5
`define I2CSTE_CTRL_TRS     4
`define I2CSTE_CTRL_BUSY    2
`define I2CSTE_CTRL_IRQ     1
`define I2CSTE_STAT_ACK     0
`define I2CSTE_STAT_RDY     1
`define I2CSTE_STAT_TXE     2
`define I2CSTE_MODE_ORDER   7
`define I2CSTE_MODE_WAIT    6
`define I2CSTE_ADDR_FS      0

`define I2CSTE_BYTE_RST     8'h00
`define I2CSTE_BYTE_ONES    8'hff
`define I2CSTE_CNT_RST      4'h0
`define I2CSTE_CNT_FIRST    4'h1
`define I2CSTE_CNT_LAST     4'h8

`endif

// ---- inc/i2cste_pkg.sv ----
// types shared by the slave transmit engine
package i2cste_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_AACK = 6'h04,
        ST_TXB  = 6'h08,
        ST_TACK = 6'h10,
        ST_WAIT = 6'h20
    } i2cste_state_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } i2cste_req_t;
endpackage

// ---- design/i2cste_top.sv ----
// slave transmit engine of an i2c bus interface with register port
//
// Behaviour
// RQ1: software enables the interface and sets mode bits before a transfer
// RQ2: matching address frame: drive ack on ninth clock, set frame flag
// RQ3: frame flag with interrupt enable set raises the interrupt output
// RQ4: read direction bit sets transmit select and enters transmit by itself
// RQ5: entering transmit sets tx empty and holds scl low until data write
// RQ6: software clears frame flag first, then writes next byte
// RQ7: data write clears tx empty; load sets tx empty, frame, ready again
// RQ8: frame flag set on rise of ninth clock after each sent byte
// RQ9: tx empty at frame end holds scl low until new byte written
// RQ10: master acks on ninth clock; level kept in ack status bit
// RQ11: tx empty clear at frame end loads buffer and sets the three flags
// RQ12: software writes all ones byte to release sda at the end
// RQ13: stop condition clears bus busy
// RQ14: frame flag moment depends on wait bit and format select bits
// RQ15: with tx empty set scl is held low after a frame, on core clock
// RQ16: scl and sda pass two latches; new level only when both agree
// RQ17: master transfer count is payload plus address byte
// RQ18: slave transfer count includes trailing all ones byte
// RQ19: transfer controller does the dummy read in master receive
// RQ20: start condition sets bus busy
// RQ21: bytes go out msb first, sda changes only while scl is low; the code sends lsb first when the mode order bit is set
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "i2cste_defines.svh"

module i2cste_top
    import i2cste_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        ce_i,
    input  wire i2cste_req_t req_i,
    output logic [7:0]       rdata_o,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             scl_o,
    output logic             scl_oe_o,
    output logic             sda_o,
    output logic             sda_oe_o,
    output logic             irq_o
);

    function automatic logic filt(input logic [1:0] l, input logic prev);
        filt = (l[0] == l[1]) ? l[1] : prev;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = !r[`I2CSTE_ADDR_FS] && (a[7:1] == r[7:1]);
    endfunction

    function automatic logic out_bit(input logic [7:0] v, input logic lsb);
        out_bit = lsb ? v[0] : v[7];
    endfunction

    function automatic logic [7:0] shift(input logic [7:0] v,
                                         input logic lsb);
        shift = lsb ? {1'h1, v[7:1]} : {v[6:0], 1'h1};
    endfunction

    logic          scl_s1, scl_s2, sda_s1, sda_s2;
    logic [1:0]    scl_l, sda_l;
    logic          scl_f, sda_f, scl_q, sda_q;
    i2cste_state_t state, next_state;
    logic [3:0]    cnt;
    logic [7:0]    rx_sh;
    logic          iface_enable, frame_irq_enable, master_select;
    logic          transmit_select, bus_busy_flag, frame_irq_flag;
    logic          ack_status_bit, transfer_ready_flag, tx_empty_flag;
    logic          bit_order_select, wait_mode;
    logic [7:0]    data_buffer_reg, tx_shift_reg;
    logic [7:0]    own_addr_reg, second_addr_reg;
    logic [7:0]    next_rdata;

    // pin sampling: two flip-flops, then the two-latch noise canceller
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            scl_s1 <= 1'h1;
            scl_s2 <= 1'h1;
            sda_s1 <= 1'h1;
            sda_s2 <= 1'h1;
            scl_l  <= 2'h3;
            sda_l  <= 2'h3;
            scl_f  <= 1'h1;
            sda_f  <= 1'h1;
            scl_q  <= 1'h1;
            sda_q  <= 1'h1;
        end else if (ce_i) begin
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            scl_l  <= {scl_l[0], scl_s2};
            sda_l  <= {sda_l[0], sda_s2};
            scl_f  <= filt(scl_l, scl_f);   // see RQ16
            sda_f  <= filt(sda_l, sda_f);   // see RQ16
            scl_q  <= scl_f;
            sda_q  <= sda_f;
        end
    end

    wire scl_rise = scl_f && !scl_q;
    wire scl_fall = !scl_f && scl_q;
    wire start_c  = scl_f && scl_q && sda_q && !sda_f;
    wire stop_c   = scl_f && scl_q && !sda_q && sda_f;

    wire wr_ctrl = req_i.wr && (req_i.addr == `I2CSTE_OFF_CTRL);
    wire wr_stat = req_i.wr && (req_i.addr == `I2CSTE_OFF_STAT);
    wire wr_data = req_i.wr && (req_i.addr == `I2CSTE_OFF_DATA);
    wire wr_own  = req_i.wr && (req_i.addr == `I2CSTE_OFF_OWN);
    wire wr_mode = req_i.wr && (req_i.addr == `I2CSTE_OFF_MODE);
    wire wr_sec  = req_i.wr && (req_i.addr == `I2CSTE_OFF_SEC);

    // a master-selected or disabled interface never answers as a slave
    wire addr_hit = iface_enable && !master_select &&
                    (hit(rx_sh, own_addr_reg) || hit(rx_sh, second_addr_reg));
    wire last_bit = (cnt == `I2CSTE_CNT_LAST);
    wire ev_aack  = (state == ST_AACK) && scl_fall;
    wire ev_match = (state == ST_ADDR) && scl_fall && last_bit && addr_hit;
    wire ev_load  = (next_state == ST_TXB) && (state != ST_TXB);
    wire ev_ack9  = (state == ST_TACK) && scl_rise;
    wire ev_tx8   = (state == ST_TXB) && scl_fall && last_bit;
    // in wait mode with addressing formats the flag comes half a clock early, on the fall of the eighth clock
    wire early    = wait_mode && !own_addr_reg[`I2CSTE_ADDR_FS] &&
                    !second_addr_reg[`I2CSTE_ADDR_FS];
    wire ev_ninth = ((state == ST_AACK) || (state == ST_TACK)) && scl_rise;
    wire ev_frame = early ? (ev_match || ev_tx8) : ev_ninth;

    always_comb begin
        next_state = state;
        if (!iface_enable || stop_c) begin
            next_state = ST_IDLE;
        end else if (start_c) begin
            next_state = ST_ADDR;
        end else begin
            unique case (state)
                ST_IDLE: next_state = ST_IDLE;
                ST_ADDR: begin
                    if (scl_fall && last_bit) begin
                        next_state = addr_hit ? ST_AACK : ST_IDLE;
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        next_state = rx_sh[0] ? ST_WAIT : ST_IDLE; // see RQ4
                    end
                end
                ST_TXB: begin
                    if (scl_fall && last_bit) begin
                        next_state = ST_TACK;
                    end
                end
                ST_TACK: begin
                    if (scl_fall) begin
                        if (ack_status_bit) begin
                            next_state = ST_IDLE;
                        end else if (tx_empty_flag) begin
                            next_state = ST_WAIT;           // see RQ9
                        end else begin
                            next_state = ST_TXB;            // see RQ11
                        end
                    end
                end
                ST_WAIT: begin
                    if (!tx_empty_flag) begin
                        next_state = ST_TXB;                // see RQ7
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            state <= ST_IDLE;
            cnt   <= `I2CSTE_CNT_RST;
        end else if (ce_i) begin
            state <= next_state;
            if (next_state == ST_ADDR && state != ST_ADDR) begin
                cnt <= `I2CSTE_CNT_RST;
            end else if (ev_load) begin
                cnt <= `I2CSTE_CNT_FIRST;
            end else if ((state == ST_ADDR && scl_rise) ||
                         (state == ST_TXB && scl_fall && !last_bit)) begin
                cnt <= cnt + `I2CSTE_CNT_FIRST;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            rx_sh <= `I2CSTE_BYTE_RST;
        end else if (ce_i && state == ST_ADDR && scl_rise) begin
            rx_sh <= {rx_sh[6:0], sda_f};
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            tx_shift_reg <= `I2CSTE_BYTE_ONES;
        end else if (ce_i) begin
            if (ev_load) begin
                tx_shift_reg <= data_buffer_reg;
            end else if (state == ST_TXB && scl_fall && !last_bit) begin
                tx_shift_reg <= shift(tx_shift_reg, bit_order_select);
            end
        end
    end

    // pins are open drain: the enable pulls low, data shows the bit level
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            sda_o    <= 1'h1;
            sda_oe_o <= 1'h0;
            scl_o    <= 1'h0;
            scl_oe_o <= 1'h0;
        end else if (ce_i) begin
            scl_o    <= 1'h0;
            scl_oe_o <= (next_state == ST_WAIT);       // see RQ5 RQ15
            if (next_state == ST_IDLE || next_state == ST_ADDR) begin
                sda_o    <= 1'h1;
                sda_oe_o <= 1'h0;
            end else if (ev_match) begin
                sda_o    <= 1'h0;                      // see RQ2
                sda_oe_o <= 1'h1;
            end else if (ev_aack || ev_tx8) begin
                sda_o    <= 1'h1;
                sda_oe_o <= 1'h0;
            end else if (ev_load) begin
                sda_o    <= out_bit(data_buffer_reg, bit_order_select);
                sda_oe_o <= !out_bit(data_buffer_reg, bit_order_select);
            end else if (state == ST_TXB && scl_fall) begin
                // next bit while scl is low, see RQ21
                sda_o    <= out_bit(shift(tx_shift_reg, bit_order_select),
                                    bit_order_select);
                sda_oe_o <= !out_bit(shift(tx_shift_reg, bit_order_select),
                                     bit_order_select);
            end
        end
    end

    // control bits written by software; a hardware set beats a clear
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            iface_enable     <= 1'h0;
            frame_irq_enable <= 1'h0;
            master_select    <= 1'h0;
            transmit_select  <= 1'h0;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                iface_enable     <= req_i.wdata[`I2CSTE_CTRL_ENA];
                frame_irq_enable <= req_i.wdata[`I2CSTE_CTRL_IEN];
                master_select    <= req_i.wdata[`I2CSTE_CTRL_MST];
                transmit_select  <= req_i.wdata[`I2CSTE_CTRL_TRS];
            end
            if (ev_aack && rx_sh[0]) begin
                transmit_select <= 1'h1;                   // see RQ4
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            frame_irq_flag <= 1'h0;
        end else if (ce_i) begin
            if (ev_frame || ev_load) begin
                frame_irq_flag <= 1'h1;             // see RQ2 RQ8 RQ14
            end else if (wr_ctrl && !req_i.wdata[`I2CSTE_CTRL_IRQ]) begin
                frame_irq_flag <= 1'h0;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            transfer_ready_flag <= 1'h0;
        end else if (ce_i) begin
            if (ev_load) begin
                transfer_ready_flag <= 1'h1;               // see RQ11
            end else if (wr_stat && !req_i.wdata[`I2CSTE_STAT_RDY]) begin
                transfer_ready_flag <= 1'h0;
            end
        end
    end

    // a write landing in the load cycle is overwritten by the set
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            tx_empty_flag <= 1'h0;
        end else if (ce_i) begin
            if (ev_load || (ev_aack && rx_sh[0])) begin
                tx_empty_flag <= 1'h1;                     // see RQ5 RQ7
            end else if (wr_data) begin
                tx_empty_flag <= 1'h0;                     // see RQ7
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            ack_status_bit <= 1'h0;
        end else if (ce_i && ev_ack9) begin
            ack_status_bit <= sda_f;                       // see RQ10
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            bus_busy_flag <= 1'h0;
        end else if (ce_i) begin
            if (start_c) begin
                bus_busy_flag <= 1'h1;                     // see RQ20
            end else if (stop_c) begin
                bus_busy_flag <= 1'h0;                     // see RQ13
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            data_buffer_reg  <= `I2CSTE_BYTE_ONES;
            own_addr_reg     <= `I2CSTE_BYTE_RST;
            second_addr_reg  <= `I2CSTE_BYTE_RST;
            bit_order_select <= 1'h0;
            wait_mode        <= 1'h0;
        end else if (ce_i) begin
            if (wr_data) begin
                data_buffer_reg <= req_i.wdata;
            end
            if (wr_own) begin
                own_addr_reg <= req_i.wdata;
            end
            if (wr_sec) begin
                second_addr_reg <= req_i.wdata;
            end
            if (wr_mode) begin
                bit_order_select <= req_i.wdata[`I2CSTE_MODE_ORDER];
                wait_mode        <= req_i.wdata[`I2CSTE_MODE_WAIT];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            irq_o <= 1'h0;
        end else if (ce_i) begin
            irq_o <= frame_irq_flag && frame_irq_enable;   // see RQ3
        end
    end

    always_comb begin
        next_rdata = `I2CSTE_BYTE_RST;
        unique case (req_i.addr)
            `I2CSTE_OFF_CTRL: begin
                next_rdata[`I2CSTE_CTRL_ENA]  = iface_enable;
                next_rdata[`I2CSTE_CTRL_IEN]  = frame_irq_enable;
                next_rdata[`I2CSTE_CTRL_MST]  = master_select;
                next_rdata[`I2CSTE_CTRL_TRS]  = transmit_select;
                next_rdata[`I2CSTE_CTRL_BUSY] = bus_busy_flag;
                next_rdata[`I2CSTE_CTRL_IRQ]  = frame_irq_flag;
            end
            `I2CSTE_OFF_STAT: begin
                next_rdata[`I2CSTE_STAT_ACK] = ack_status_bit;
                next_rdata[`I2CSTE_STAT_RDY] = transfer_ready_flag;
                next_rdata[`I2CSTE_STAT_TXE] = tx_empty_flag;
            end
            `I2CSTE_OFF_DATA: next_rdata = data_buffer_reg;
            `I2CSTE_OFF_OWN:  next_rdata = own_addr_reg;
            `I2CSTE_OFF_MODE: begin
                next_rdata[`I2CSTE_MODE_ORDER] = bit_order_select;
                next_rdata[`I2CSTE_MODE_WAIT]  = wait_mode;
            end
            `I2CSTE_OFF_SEC:  next_rdata = second_addr_reg;
            default:          next_rdata = `I2CSTE_BYTE_RST;
        endcase
    end

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            rdata_o <= `I2CSTE_BYTE_RST;
        end else if (ce_i) begin
            rdata_o <= req_i.rd ? next_rdata : `I2CSTE_BYTE_RST;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i || !ce_i);

    a_addr_ack_drive: assert property (      // see RQ2
        ev_match |=> (state == ST_AACK) && sda_oe_o && !sda_o)
        else $error("address ack not driven");
    a_irq_out_follow: assert property (      // see RQ3
        frame_irq_flag && frame_irq_enable ##1 ce_i |-> irq_o)
        else $error("interrupt output missing");
    a_trs_auto_set: assert property (        // see RQ4
        ev_aack && rx_sh[0] |=> transmit_select && tx_empty_flag)
        else $error("transmit mode not entered");
    a_scl_held_wait: assert property (       // see RQ9
        state == ST_WAIT && tx_empty_flag && !start_c && !stop_c
        |=> scl_oe_o && !scl_o)
        else $error("scl not held while empty");
    a_write_clears: assert property (        // see RQ7
        wr_data && !ev_load && !(ev_aack && rx_sh[0]) |=> !tx_empty_flag)
        else $error("write did not clear tx empty");
    a_load_flags: assert property (          // see RQ11
        ev_load |=> tx_empty_flag && frame_irq_flag && transfer_ready_flag
                    && !scl_oe_o)
        else $error("load flags wrong");
    a_ack_capture: assert property (         // see RQ10
        ev_ack9 |=> ack_status_bit == $past(sda_f))
        else $error("ack level not kept");
    a_stop_busy: assert property (           // see RQ13
        stop_c |=> !bus_busy_flag)
        else $error("busy not cleared on stop");
    a_start_busy: assert property (          // see RQ20
        start_c |=> bus_busy_flag)
        else $error("busy not set on start");
    a_filter_hold: assert property (         // see RQ16
        scl_l[0] != scl_l[1] |=> scl_f == $past(scl_f))
        else $error("filter passed disagreeing level");
    a_sda_scl_low: assert property (         // see RQ21
        state == ST_TXB && $changed(sda_oe_o) |-> !scl_f)
        else $error("sda changed while scl high");

    c_addr_read: cover property (ev_aack && rx_sh[0]);
    c_wait_load: cover property (state == ST_WAIT ##[1:200] ev_load);
    c_nack_end:  cover property (ev_ack9 && sda_f);

endmodule

// ---- verif/i2cste_master_model.sv ----
// behavioural i2c bus master that clocks bytes out of the slave
`timescale 1ns/1ps
module i2cste_master_model (
    input  wire logic scl_w_i,
    input  wire logic sda_w_i,
    output logic      scl_low_o,
    output logic      sda_low_o
);
    // four quarters make the 125 ns link clock period
    localparam realtime QTR = 31.25;
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end
    // the slave may stretch a released scl; give up after a bound
    task automatic scl_high();
        int n;
        n = 0;
        scl_low_o = 1'b0;
        while (scl_w_i !== 1'b1 && n < 20000) begin
            #4;
            n++;
        end
    endtask
    // sda only moves while scl is low
    task automatic clk_bit(input logic b, output logic s);
        sda_low_o = ~b;
        #QTR;
        scl_high();
        #QTR;
        s = sda_w_i;
        #QTR;
        scl_low_o = 1'b1;
        #QTR;
    endtask
    task automatic start();
        sda_low_o = 1'b0;
        scl_high();
        #QTR;
        sda_low_o = 1'b1;
        #QTR;
        scl_low_o = 1'b1;
        #QTR;
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        #QTR;
        scl_high();
        #QTR;
        sda_low_o = 1'b0;
        #QTR;
    endtask
    // 3 ns rise of sda with scl high: shorter than one core clock
    task automatic glitch();
        sda_low_o = 1'b1;
        #QTR;
        scl_high();
        #QTR;
        sda_low_o = 1'b0;
        #3;
        sda_low_o = 1'b1;
        #QTR;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], s);
        end
        clk_bit(1'b1, ack);
    endtask
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(nack, s);
    endtask
endmodule

// ---- verif/test_i2c_slave_transmit_engine.sv ----
// self-checking bench of the slave transmit engine
`timescale 1ns/1ps
`include "i2cste_defines.svh"
module test_i2c_slave_transmit_engine
    import i2cste_pkg::*;
;
    logic        core_clk_i = 1'b0;
    logic        nrst_i     = 1'b0;
    i2cste_req_t req        = '0;
    logic [7:0]  rdata;
    logic        scl_o, scl_oe, sda_o, sda_oe, irq;
    logic        scl_low, sda_low;
    wire logic   scl_w = ~(scl_low | scl_oe);
    wire logic   sda_w = ~(sda_low | sda_oe);
    int          miscompares = 0;
    int          n_checks    = 0;

    always #2 core_clk_i = ~core_clk_i;

    i2cste_top DUT (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .ce_i       (1'b1),
        .req_i      (req),
        .rdata_o    (rdata),
        .scl_i      (scl_w),
        .sda_i      (sda_w),
        .scl_o      (scl_o),
        .scl_oe_o   (scl_oe),
        .sda_o      (sda_o),
        .sda_oe_o   (sda_oe),
        .irq_o      (irq)
    );

    i2cste_master_model bus_master (
        .scl_w_i   (scl_w),
        .sda_w_i   (sda_w),
        .scl_low_o (scl_low),
        .sda_low_o (sda_low)
    );

    task automatic give_verdict();
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i);
        req <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_i);
        req <= '0;
        #1;
        d = rdata;
    endtask

    task automatic t_reset();
        logic [7:0] v;
        rd(`I2CSTE_OFF_CTRL, v);
        chk("ctrl", 8'h00, v & 8'hf6);
        rd(`I2CSTE_OFF_DATA, v);
        chk("data", `I2CSTE_BYTE_ONES, v);
        chk("pins", 8'h01, {6'h0, scl_o, sda_o});
        rd(3'h6, v);
        chk("unmapped", 8'h00, v);
        chk("irq", 8'h00, {7'h0, irq});
    endtask

    task automatic t_transmit();
        logic [7:0] v, d1, d2, d3;
        logic       ack;
        int         n;
        wr(`I2CSTE_OFF_OWN, 8'h54);
        wr(`I2CSTE_OFF_CTRL, 8'hc0);
        bus_master.start();
        bus_master.wr_byte(8'h55, ack);
        chk("addr ack", 8'h00, {7'h0, ack});
        cyc(20);
        chk("scl hold", 8'h02, {6'h0, scl_oe, scl_o});
        chk("irq", 8'h01, {7'h0, irq});
        rd(`I2CSTE_OFF_CTRL, v);
        chk("ctrl", 8'h16, v & 8'h16);
        rd(`I2CSTE_OFF_STAT, v);
        chk("tx empty", 8'h04, v & 8'h04);
        fork
            begin
                bus_master.rd_byte(1'b0, d1);
                bus_master.rd_byte(1'b0, d2);
                bus_master.rd_byte(1'b1, d3);
            end
            begin
                wr(`I2CSTE_OFF_CTRL, 8'hd0);
                wr(`I2CSTE_OFF_DATA, 8'ha5);
                cyc(4);
                rd(`I2CSTE_OFF_STAT, v);
                chk("reload", 8'h06, v & 8'h06);
                rd(`I2CSTE_OFF_CTRL, v);
                chk("frame", 8'h02, v & 8'h02);
                wr(`I2CSTE_OFF_CTRL, 8'hd0);
                wr(`I2CSTE_OFF_DATA, 8'h3c);
                // after the second load only the ninth rise may set it
                v = 8'h00;
                n = 0;
                while (v[2] !== 1'b1 && n < 1000) begin
                    rd(`I2CSTE_OFF_STAT, v);
                    n++;
                end
                wr(`I2CSTE_OFF_CTRL, 8'hd0);
                n = 0;
                while (scl_oe !== 1'b1 && n < 1000) begin
                    cyc(1);
                    n++;
                end
                chk("stretch", 8'h02, {6'h0, scl_oe, scl_o});
                rd(`I2CSTE_OFF_CTRL, v);
                chk("ninth", 8'h02, v & 8'h02);
                rd(`I2CSTE_OFF_STAT, v);
                chk("ack", 8'h04, v & 8'h05);
                wr(`I2CSTE_OFF_MODE, 8'h80);
                wr(`I2CSTE_OFF_CTRL, 8'hd0);
                wr(`I2CSTE_OFF_DATA, 8'h35);
            end
        join
        chk("byte one", 8'ha5, d1);
        chk("byte two", 8'h3c, d2);
        // lsb first turns the written byte around on the wire
        chk("byte lsb", 8'hac, d3);
        rd(`I2CSTE_OFF_STAT, v);
        chk("nack", 8'h05, v & 8'h05);
        rd(`I2CSTE_OFF_CTRL, v);
        chk("frame", 8'h02, v & 8'h02);
        wr(`I2CSTE_OFF_DATA, `I2CSTE_BYTE_ONES);
        bus_master.stop();
        cyc(20);
        rd(`I2CSTE_OFF_CTRL, v);
        chk("busy", 8'h00, v & 8'h04);
    endtask

    task automatic t_nomatch();
        logic [7:0] v;
        logic       ack;
        // address bits agree but the format bit forbids a match
        wr(`I2CSTE_OFF_OWN, 8'h57);
        wr(`I2CSTE_OFF_CTRL, 8'hc0);
        bus_master.start();
        bus_master.wr_byte(8'h57, ack);
        chk("no ack", 8'h01, {7'h0, ack});
        rd(`I2CSTE_OFF_CTRL, v);
        chk("no frame", 8'h04, v & 8'h16);
        bus_master.glitch();
        cyc(20);
        rd(`I2CSTE_OFF_CTRL, v);
        chk("filter", 8'h04, v & 8'h04);
        bus_master.stop();
        cyc(20);
        rd(`I2CSTE_OFF_CTRL, v);
        chk("busy", 8'h00, v & 8'h04);
    endtask

    initial begin
        #150000;
        miscompares++;
        give_verdict();
    end

    initial begin
        repeat (6) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        cyc(8);
        t_reset();
        t_transmit();
        t_nomatch();
        give_verdict();
    end
endmodule
